// ==== design/spi_flash_write_protect_sequencer.sv ====
// serial flash command sequencer with write protection
`timescale 1ns/1ps
module spi_flash_write_protect_sequencer
    import flash_seq_pkg::*;
#(
    parameter int ADDR_W = ADDR_BITS,
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int STAT_CYCLES = STAT_CYC,
    parameter int SECT_CYCLES = SECT_CYC,
    parameter int CHIP_CYCLES = CHIP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic busy,
    output logic write_latch
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int SEC_LSB = ADDR_W - SECT_BITS;
    localparam int WALK_W = ADDR_W + 1;
    localparam logic [WALK_W-1:0] PAGE_LEN = WALK_W'(1 << PAGE_BITS);
    localparam logic [WALK_W-1:0] SECT_LEN = WALK_W'(1 << SEC_LSB);
    localparam logic [WALK_W-1:0] ALL_LEN = WALK_W'(DEPTH);

    // ===========================================
    // parameter check
    if (ADDR_W < 10 || ADDR_W > 24 || PROG_CYCLES < 1 || STAT_CYCLES < 1
        || SECT_CYCLES < 1 || CHIP_CYCLES < 1) begin : g_bad_param
        $error("unsupported sequencer parameters");
    end

    typedef enum logic [1:0] {S_IDLE, S_PROG, S_ERASE, S_STAT} seq_state_t;

    function automatic logic op_is(input logic [7:0] c, input logic [7:0] op);
        return (c & OP_MASK) == op;
    endfunction : op_is

    function automatic logic sect_locked(input logic [1:0] bp,
                                         input logic [1:0] sec);
        return (bp == BP_ALL) || (bp == BP_HALF && sec[1])
            || (bp == BP_QUARTER && sec == SECT_TOP);
    endfunction : sect_locked

    // ===========================================
    // storage: array, page buffer
    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] pbuf [0:(1<<PAGE_BITS)-1];
    logic [(1<<PAGE_BITS)-1:0] pvalid_ff;

    // ===========================================
    // link side, clocked by the serial clock
    logic [2:0] bit_ff;
    logic [2:0] byte_ff;
    logic [6:0] shift_ff;
    logic accept_ff, send_stat_ff, send_data_ff;
    logic [7:0] cmd_ff, stat_data_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic keep_ff, addr_done_ff, data_seen_ff;
    logic tog_ff = 1'h0;
    logic [4:0] stat_s1_ff, stat_s2_ff;
    logic busy_ff, wel_ff, protect_pin_enable_bit_ff;
    logic [1:0] bp_ff;
    logic so_ff, so_oe_ff;
    logic [7:0] rx_byte, stat_rd, idle_stat, rd_byte;
    logic byte_end, cmd_end, addr_end, data_end, busy_s, cmd_take;
    logic stat_end;
    logic [PAGE_BITS-1:0] pg_idx;

    assign rx_byte = {shift_ff, si};
    assign byte_end = bit_ff == 3'h7;
    assign cmd_end = byte_end && byte_ff == FB_CMD;
    assign addr_end = byte_end && byte_ff == FB_ADDR_LAST;
    assign data_end = byte_end && byte_ff == FB_DATA;
    assign stat_end = byte_end && byte_ff == FB_STAT;
    assign busy_s = stat_s2_ff[0];
    assign cmd_take = !busy_s || op_is(rx_byte, OP_RD_STAT);
    assign pg_idx = addr_ff[PAGE_BITS-1:0];
    assign rd_byte = mem[addr_ff];

    // status seen by the link; all ones while a cycle runs
    always_comb begin
        idle_stat = 8'h00;
        idle_stat[ST_PROTECT_PIN_ENABLE_BIT] = stat_s2_ff[4];
        idle_stat[ST_BP_HI] = stat_s2_ff[3];
        idle_stat[ST_BP_LO] = stat_s2_ff[2];
        idle_stat[ST_WEL] = stat_s2_ff[1];
        idle_stat[ST_BUSY] = 1'h0;
    end
    assign stat_rd = busy_s ? ST_BUSY_BYTE : idle_stat;

    // status bits cross into the link clock; sck runs during a read
    always_ff @(posedge sck) begin
        stat_s1_ff <= {protect_pin_enable_bit_ff, bp_ff, wel_ff, busy_ff};
        stat_s2_ff <= stat_s1_ff;
    end

    // bit and byte counters, cleared by the frame's own chip select
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_ff <= 3'h0;
            byte_ff <= FB_CMD;
            shift_ff <= 7'h00;
            accept_ff <= 1'h0;
            send_stat_ff <= 1'h0;
            send_data_ff <= 1'h0;
        end else begin
            bit_ff <= bit_ff + 3'h1;
            shift_ff <= rx_byte[6:0];
            if (byte_end && byte_ff != FB_DATA) begin
                byte_ff <= byte_ff + 3'h1;
            end
            if (cmd_end) begin
                accept_ff <= cmd_take;
                send_stat_ff <= op_is(rx_byte, OP_RD_STAT);
            end
            if (addr_end) begin
                send_data_ff <= accept_ff && op_is(cmd_ff, OP_READ);
            end
        end
    end

    // frame record; kept past chip select so the clock side can read it
    always_ff @(posedge sck) begin
        if (cmd_end) begin
            cmd_ff <= rx_byte;
            keep_ff <= cmd_take;
            tog_ff <= ~tog_ff;
            addr_done_ff <= 1'h0;
            data_seen_ff <= 1'h0;
        end
        if (cmd_end && cmd_take && op_is(rx_byte, OP_PROG)) begin
            pvalid_ff <= '0;
        end
        if (byte_end && byte_ff != FB_CMD && byte_ff != FB_DATA) begin
            addr_ff <= {addr_ff[ADDR_W-9:0], rx_byte};
        end
        if (addr_end) begin
            addr_done_ff <= 1'h1;
        end
        // status write takes only the byte right after its opcode
        if (stat_end && accept_ff && op_is(cmd_ff, OP_WR_STAT)) begin
            data_seen_ff <= 1'h1;
            stat_data_ff <= rx_byte;
        end
        // after the address a read never looks at si
        if (data_end && accept_ff && !send_data_ff) begin
            data_seen_ff <= 1'h1;
            if (op_is(cmd_ff, OP_PROG)) begin
                pbuf[pg_idx] <= rx_byte;
                pvalid_ff[pg_idx] <= 1'h1;
                addr_ff[PAGE_BITS-1:0] <= pg_idx + 1'b1;
            end
        end
        if (send_data_ff && byte_end) begin
            addr_ff <= addr_ff + 1'b1;
        end
    end

    // serial output changes on the falling edge
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_ff <= 1'h0;
            so_oe_ff <= 1'h0;
        end else begin
            so_oe_ff <= send_stat_ff || send_data_ff;
            so_ff <= send_stat_ff ? stat_rd[~bit_ff] : rd_byte[~bit_ff];
        end
    end

    // ===========================================
    // clock side: sequencer
    logic cs_s1_ff, cs_s2_ff, cs_d_ff, wp_s1_ff, wp_s2_ff;
    logic tog_s1_ff, tog_s2_ff, seen_ff;
    seq_state_t state_ff, ld_state;
    logic [2:0] pend_ff;
    logic [31:0] tmr_ff, ld_tmr;
    logic [WALK_W-1:0] walk_ff, walk_end_ff, ld_end;
    logic [ADDR_W-1:0] base_ff, ld_base, wa;
    logic frame_end, new_cmd, hw_prot, addr_lock, op_write;
    logic go_prog, go_sect, go_chip, go_stat, go_any, cyc_done;
    logic mem_we;
    logic [7:0] mem_wd;

    // pins and the toggle cross on two flip-flops each
    always_ff @(posedge clk) begin
        cs_s1_ff <= cs_n;
        cs_s2_ff <= cs_s1_ff;
        cs_d_ff <= cs_s2_ff;
        wp_s1_ff <= wp_n;
        wp_s2_ff <= wp_s1_ff;
        tog_s1_ff <= tog_ff;
        tog_s2_ff <= tog_s1_ff;
    end

    // frame fields are static once chip select is high
    assign frame_end = cs_s2_ff && !cs_d_ff;
    assign new_cmd = frame_end && (tog_s2_ff != seen_ff) && keep_ff;
    assign hw_prot = protect_pin_enable_bit_ff && !wp_s2_ff;
    assign addr_lock = sect_locked(bp_ff, addr_ff[ADDR_W-1:SEC_LSB]);
    assign op_write = op_is(cmd_ff, OP_PROG) || op_is(cmd_ff, OP_WR_STAT)
        || op_is(cmd_ff, OP_SECT_ERASE) || op_is(cmd_ff, OP_CHIP_ERASE);

    // starts; a write command without the latch simply falls away
    assign go_prog = op_is(cmd_ff, OP_PROG) && wel_ff && addr_done_ff
        && data_seen_ff && !addr_lock;
    assign go_sect = op_is(cmd_ff, OP_SECT_ERASE) && wel_ff
        && addr_done_ff && !addr_lock;
    assign go_chip = op_is(cmd_ff, OP_CHIP_ERASE) && wel_ff;
    assign go_stat = op_is(cmd_ff, OP_WR_STAT) && wel_ff && data_seen_ff
        && !hw_prot;
    assign go_any = go_prog || go_sect || go_chip || go_stat;

    // load values for the chosen cycle
    assign ld_state = go_prog ? S_PROG : (go_stat ? S_STAT : S_ERASE);
    assign ld_tmr = go_prog ? 32'(PROG_CYCLES) : go_sect ? 32'(SECT_CYCLES)
        : go_chip ? 32'(CHIP_CYCLES) : 32'(STAT_CYCLES);
    assign ld_end = go_prog ? PAGE_LEN : go_sect ? SECT_LEN
        : go_chip ? ALL_LEN : '0;
    assign ld_base = go_prog ? {addr_ff[ADDR_W-1:PAGE_BITS], 8'h00}
        : go_sect ? {addr_ff[ADDR_W-1:SEC_LSB], {SEC_LSB{1'b0}}} : '0;
    assign cyc_done = tmr_ff == 32'h0 && walk_ff == walk_end_ff;

    // array walk: page copy of supplied bytes, or erase of unlocked bytes
    assign wa = base_ff | walk_ff[ADDR_W-1:0];
    assign mem_we = walk_ff != walk_end_ff && (state_ff == S_PROG
        ? pvalid_ff[walk_ff[PAGE_BITS-1:0]]
        : state_ff == S_ERASE && !sect_locked(bp_ff, wa[ADDR_W-1:SEC_LSB]));
    assign mem_wd = state_ff == S_PROG ? pbuf[walk_ff[PAGE_BITS-1:0]]
        : ERASED;

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[wa] <= mem_wd;
        end
    end

    // seen copy tracks the toggle while deselected, so a short reset
    // cannot leave it unknown; a frame toggles only after cs falls
    always_ff @(posedge clk) begin
        if (rst || cs_s2_ff) begin
            seen_ff <= tog_s2_ff;
        end
    end

    // main sequencer; busy frames obey nothing but status reads
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= S_IDLE;
            busy_ff <= 1'h0;
            wel_ff <= 1'h0;
            protect_pin_enable_bit_ff <= PROTECT_PIN_ENABLE_BIT_RST;
            bp_ff <= BP_RST;
            pend_ff <= 3'h0;
            tmr_ff <= 32'h0;
            walk_ff <= '0;
            walk_end_ff <= '0;
            base_ff <= '0;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (new_cmd && op_is(cmd_ff, OP_SET_WEL)) begin
                        wel_ff <= 1'h1;
                    end
                    if (new_cmd && op_is(cmd_ff, OP_CLR_WEL)) begin
                        wel_ff <= 1'h0;
                    end
                    if (new_cmd && go_any) begin
                        state_ff <= ld_state;
                        busy_ff <= 1'h1;
                        tmr_ff <= ld_tmr;
                        walk_ff <= '0;
                        walk_end_ff <= ld_end;
                        base_ff <= ld_base;
                        pend_ff <= {stat_data_ff[ST_PROTECT_PIN_ENABLE_BIT],
                            stat_data_ff[ST_BP_HI], stat_data_ff[ST_BP_LO]};
                    end
                end
                S_PROG, S_ERASE, S_STAT: begin
                    if (tmr_ff != 32'h0) begin
                        tmr_ff <= tmr_ff - 32'h1;
                    end
                    if (walk_ff != walk_end_ff) begin
                        walk_ff <= walk_ff + 1'b1;
                    end
                    if (cyc_done) begin
                        state_ff <= S_IDLE;
                        busy_ff <= 1'h0;
                        wel_ff <= 1'h0;
                        if (state_ff == S_STAT) begin
                            protect_pin_enable_bit_ff <= pend_ff[2];
                            bp_ff <= pend_ff[1:0];
                        end
                    end
                end
            endcase
        end
    end

    assign so = so_ff;
    assign so_oe = so_oe_ff;
    assign busy = busy_ff;
    assign write_latch = wel_ff;

    // ===========================================
    // checks
    a_busy_ignores_cmd: assert property (
        @(posedge clk) disable iff (rst)
        busy_ff && new_cmd && !cyc_done |=> $stable(wel_ff) && busy_ff)
        else $error("command obeyed during internal cycle");
    a_latch_cleared_end: assert property (
        @(posedge clk) disable iff (rst) $fell(busy_ff) |-> !wel_ff)
        else $error("write latch survived cycle end");
    a_hw_lock_status: assert property (
        @(posedge clk) disable iff (rst)
        new_cmd && !busy_ff && op_is(cmd_ff, OP_WR_STAT) && hw_prot
        |=> !busy_ff ##1 $stable(protect_pin_enable_bit_ff))
        else $error("status write under hardware protection");
    a_locked_untouched: assert property (
        @(posedge clk) disable iff (rst)
        mem_we |-> !sect_locked(bp_ff, wa[ADDR_W-1:SEC_LSB]))
        else $error("write into locked sector");
    a_enable_held_low: assert property (
        @(posedge clk) disable iff (rst)
        protect_pin_enable_bit_ff && !wp_s2_ff ##1 !wp_s2_ff |-> protect_pin_enable_bit_ff)
        else $error("protect enable cleared while pin low");
    a_need_write_latch: assert property (
        @(posedge clk) disable iff (rst)
        new_cmd && !busy_ff && !wel_ff && op_write |=> !busy_ff [*2])
        else $error("write command ran without latch");
    a_busy_flag_state: assert property (
        @(posedge clk) disable iff (rst)
        busy_ff == (state_ff != S_IDLE))
        else $error("busy flag disagrees with cycle");
    a_start_on_cs_rise: assert property (
        @(posedge clk) disable iff (rst) $rose(busy_ff) |-> $past(frame_end))
        else $error("cycle started without chip select rise");
    a_page_bound_write: assert property (
        @(posedge clk) disable iff (rst) mem_we && state_ff == S_PROG
        |-> wa[ADDR_W-1:PAGE_BITS] == base_ff[ADDR_W-1:PAGE_BITS])
        else $error("program left its page");
    a_read_needs_take: assert property (
        @(posedge sck) disable iff (cs_n) send_data_ff |-> accept_ff)
        else $error("read served during internal cycle");
    c_prog_cycle: cover property (@(posedge clk) disable iff (rst)
        go_prog && new_cmd ##1 busy_ff);
    c_sect_erase: cover property (@(posedge clk) disable iff (rst)
        go_sect && new_cmd);
    c_stat_write: cover property (@(posedge clk) disable iff (rst)
        state_ff == S_STAT ##1 !busy_ff);
    c_read_data: cover property (@(posedge sck) disable iff (cs_n)
        send_data_ff && byte_end);
endmodule : spi_flash_write_protect_sequencer

// ==== design/flash_seq_pkg.sv ====
// constants shared by the serial flash sequencer
package flash_seq_pkg;
    // ===========================================
    // opcodes, bit 3 is a don't-care
    localparam logic [7:0] OP_MASK = 8'hf7;
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLR_WEL = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h62;
    // ===========================================
    // status byte layout and reset values
    localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL = 1;
    localparam int ST_BUSY = 0;
    localparam logic [7:0] ST_BUSY_BYTE = 8'hff;
    localparam logic PROTECT_PIN_ENABLE_BIT_RST = 1'h0;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] SECT_TOP = 2'h3;
    localparam logic [7:0] ERASED = 8'hff;
    // ===========================================
    // array geometry and frame byte slots
    localparam int ADDR_BITS = 18;
    localparam int PAGE_BITS = 8;
    localparam int SECT_BITS = 2;
    localparam logic [2:0] FB_CMD = 3'h0;
    localparam logic [2:0] FB_STAT = 3'h1;
    localparam logic [2:0] FB_ADDR_LAST = 3'h3;
    localparam logic [2:0] FB_DATA = 3'h4;
    // ===========================================
    // internal cycle times at the 10 MHz clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int PROG_TIME_US = 100;
    localparam int STAT_TIME_US = 100;
    localparam int SECT_ERASE_TIME_MS = 2000;
    localparam int CHIP_ERASE_TIME_S = 4;
    localparam int PROG_CYC = PROG_TIME_US * CLK_PER_US;
    localparam int STAT_CYC = STAT_TIME_US * CLK_PER_US;
    localparam int SECT_CYC = SECT_ERASE_TIME_MS * (CLK_HZ / 1000);
    localparam int CHIP_CYC = CHIP_ERASE_TIME_S * CLK_HZ;
endpackage : flash_seq_pkg

// ==== testbench/spi_master_model.sv ====
// serial bus master model that drives the flash in clock mode 0
`timescale 1ns/1ps
module spi_master_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    // ==========================================
    // idle bus: clock stands low, select high
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // ==========================================
    // one frame: header bytes out, then nrx bytes in, msb first
    task automatic frame(input logic [7:0] tx[$], input int nrx,
            output logic [7:0] rx[$], output logic oe_ok);
        logic [7:0] b;
        rx = {};
        oe_ok = 1'b1;
        cs_n = 1'b0;
        #24;
        for (int i = 0; i < tx.size() + nrx; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                // after the header si carries junk the device must ignore
                si = (i < tx.size()) ? b[k] : ~si;
                #24 sck = 1'b1;
                b[k] = so;
                if (i >= tx.size() && so_oe !== 1'b1) oe_ok = 1'b0;
                #24 sck = 1'b0;
            end
            if (i >= tx.size()) rx.push_back(b);
        end
        // select rises in the low phase right after the last bit
        #12 cs_n = 1'b1;
        si = ~si;
        // gap well above the 300 ns the sync needs
        #500;
    endtask : frame
endmodule : spi_master_model

// ==== testbench/spi_flash_write_protect_sequencer_bench.sv ====
// self-checking bench for the serial flash command sequencer
`timescale 1ns/1ps
module spi_flash_write_protect_sequencer_bench;
    import flash_seq_pkg::*;
    // short cycles keep the run small; erase floor still dominates
    localparam int CYC = 300;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe, busy, write_latch;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] mem [int];
    logic [7:0] rx[$];
    logic oe_ok;
    logic protect_pin_enable_bit = 1'b0;
    logic wel = 1'b0;
    logic [1:0] bp = 2'h0;
    logic [7:0] wcmd [4] = '{OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE,
        OP_WR_STAT};
    logic [7:0] lcmd [4] = '{OP_SET_WEL, OP_CLR_WEL, OP_SET_WEL | 8'h08,
        OP_CLR_WEL | 8'h08};

    always #50 clk = ~clk;

    spi_flash_write_protect_sequencer #(
        .PROG_CYCLES(CYC), .STAT_CYCLES(CYC),
        .SECT_CYCLES(CYC), .CHIP_CYCLES(CYC)
    ) i_spi_flash_write_protect_sequencer (
        .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy),
        .write_latch(write_latch));
    spi_master_model i_spi_master_model (.sck(sck), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe));

    // ==========================================
    // hang guard, ceiling above the sector erase floor
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            mismatches++;
            summarize();
        end
    end

    // ==========================================
    // helpers
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] model_rd(input int addr);
        return mem.exists(addr) ? mem[addr] : ERASED;
    endfunction : model_rd

    task automatic send(input logic [7:0] q[$], input int n);
        i_spi_master_model.frame(q, n, rx, oe_ok);
    endtask : send

    task automatic stat_chk();
        send({OP_RD_STAT}, 2);
        check("status", {protect_pin_enable_bit, 3'h0, bp, wel, 1'b0}, rx[0]);
        check("status repeat", {protect_pin_enable_bit, 3'h0, bp, wel, 1'b0}, rx[1]);
        check("latch pin", {7'h0, wel}, {7'h0, write_latch});
    endtask : stat_chk

    // a running cycle answers only the status command
    task automatic wait_done();
        @(posedge clk);
        #5 check("busy pin", 8'h01, {7'h0, busy});
        send({OP_RD_STAT}, 1);
        check("busy status", ST_BUSY_BYTE, rx[0]);
        send({OP_READ, 8'h00, 8'h00, 8'h00}, 1);
        check("read while busy", 8'h00, {7'h0, oe_ok});
        for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(posedge clk);
        #5 wel = 1'b0;
        stat_chk();
    endtask : wait_done

    task automatic refused();
        repeat (8) @(posedge clk);
        #5 check("no cycle", 8'h00, {7'h0, busy});
        stat_chk();
    endtask : refused

    task automatic wr(input logic [7:0] q[$], input bit ok);
        send({OP_SET_WEL}, 0);
        wel = 1'b1;
        send(q, 0);
        if (ok) wait_done();
        else refused();
    endtask : wr

    task automatic prog(input int addr, input int n, input bit ok);
        logic [7:0] q[$];
        int base;
        base = addr & 32'h3ff00;
        q = {OP_PROG, 8'(addr >> 16), 8'(addr >> 8), 8'(addr)};
        for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            // later bytes on the same offset win
            if (ok) mem[base | ((addr + i) & 32'hff)] = q[4 + i];
        end
        wr(q, ok);
    endtask : prog

    task automatic rd_chk(input int addr, input int n);
        send({OP_READ, 8'(addr >> 16), 8'(addr >> 8), 8'(addr)}, n);
        for (int i = 0; i < n; i++)
            check("array", model_rd((addr + i) & 32'h3ffff), rx[i]);
    endtask : rd_chk

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h7bca1dd4));
        repeat (2) @(posedge clk);
        #5 rst = 1'b0;
        repeat (4) @(posedge clk);
        stat_chk();
        // write commands with the latch clear must do nothing
        foreach (wcmd[i]) begin
            send({wcmd[i], 8'hfc, 8'h00, 8'h00, 8'hfc}, 0);
            refused();
        end
        // bit 3 of the opcode is a don't-care
        foreach (lcmd[i]) begin
            send({lcmd[i]}, 0);
            wel = lcmd[i][1];
            stat_chk();
        end
        // erase sector 0 so the array content is known
        wr({OP_SECT_ERASE, 8'hfc, 8'h12, 8'h34}, 1'b1);
        prog(32'h0001fe, 4, 1'b1);
        prog(32'hfc0210, 258, 1'b1);
        rd_chk(32'h0000fe, 32'h122);
        send({OP_READ, 8'hff, 8'hff, 8'hff}, 2);
        check("read wrap", ERASED, rx[1]);
        // full lock with hardware protection, then quarter and half locks with the protect enable bit clear
        protect_pin_enable_bit = 1'b1;
        bp = BP_ALL;
        wr({OP_WR_STAT, 8'hfc}, 1'b1);
        @(posedge clk);
        #5 wp_n = 1'b0;
        wr({OP_WR_STAT, 8'h00}, 1'b0);
        prog(32'h000300, 1, 1'b0);
        wr({OP_SECT_ERASE, 8'h00, 8'h01, 8'h00}, 1'b0);
        rd_chk(32'h000100, 2);
        rd_chk(32'h000300, 1);
        @(posedge clk);
        #5 wp_n = 1'b1;
        protect_pin_enable_bit = 1'b0;
        bp = BP_QUARTER;
        wr({OP_WR_STAT, 8'h04}, 1'b1);
        wr({OP_SECT_ERASE, 8'h03, 8'h00, 8'h00}, 1'b0);
        @(posedge clk);
        #5 wp_n = 1'b0;
        bp = BP_HALF;
        wr({OP_WR_STAT, 8'h08}, 1'b1);
        prog(32'h020000, 1, 1'b0);
        prog(32'h000300, 1, 1'b1);
        rd_chk(32'h000300, 1);
        summarize();
    end
endmodule : spi_flash_write_protect_sequencer_bench
